/* File: rtl/tsw_cml_decode.sv */
`timescale 1ns/1ps
`include "tsw_regs.svh"
// Pure decode of one low connection word into its fields
module tsw_cml_decode (
    input wire logic [15:0] word,
    output tsw_pkg::tsw_outmode_e mode,
    output logic law_conv,
    output logic var_delay,
    output logic [4:0] src_stream,
    output logic [7:0] src_chan,
    output logic [7:0] msg_byte
);
    wire special_mode_select = word[`TSW_CML_SPECIAL_BIT];
    wire [1:0] per_channel_mode_code = word[`TSW_CML_MODE_HI:`TSW_CML_MODE_LO];

    // Special mode chosen by the per-channel code
    always_comb
    begin
        if (!special_mode_select)
            mode = tsw_pkg::TSW_OUT_SWITCH;
        else
        begin
            case (per_channel_mode_code)
                2'h0: mode = tsw_pkg::TSW_OUT_TRISTATE;
                2'h1: mode = tsw_pkg::TSW_OUT_MESSAGE;
                2'h2: mode = tsw_pkg::TSW_OUT_BER;
                default: mode = tsw_pkg::TSW_OUT_RESERVED;
            endcase
        end
    end

    // Fields meaningful in switching mode, except msg_byte which is meaningful in message mode and law_conv which is meaningful in both
    assign law_conv = word[`TSW_CML_LAW_EN_BIT];
    assign var_delay = !special_mode_select && word[`TSW_CML_VC_BIT];
    assign src_stream = word[`TSW_CML_SRC_STR_HI:`TSW_CML_SRC_STR_LO];
    assign src_chan = word[`TSW_CML_SRC_CH_HI:`TSW_CML_SRC_CH_LO];
    assign msg_byte = word[`TSW_CML_MSG_HI:`TSW_CML_MSG_LO];
endmodule // tsw_cml_decode

/* File: rtl/tsw_mem_map.sv */
`timescale 1ns/1ps
`include "tsw_regs.svh"

// Overview of operation
// (R01) Address bit 13 high sends host access to data or connection memory.
// (R02) Address bit 13 low sends host access to internal registers.
// (R03) Control bits 1..0 pick data memory, connection low or connection high.
// (R04) Address bits 12..8 give stream, bits 7..0 give channel.
// (R05) Usable channels per stream are 32, 64, 128 or 256 by rate.
// (R06) Low word bit 0 clear means normal switching from the source fields.
// (R07) Bit 15 clear passes data unconverted and ignores the high word.
// (R08) Bit 15 set converts law using the method in the high word.
// (R09) Bit 14 clear takes output data from constant-delay memory.
// (R10) Bit 14 set takes output data from variable-delay memory.
// (R11) Host sets the global variable-delay enable before selecting variable delay.
// (R12) Low word bits 13..9 hold source stream, bits 8..1 source channel.
// (R13) Host should write the high word before enabling law conversion.
// (R14) Bit 0 set: bits 2..1 pick tristate, message, BER, or reserved.
// (R15) Each connection word is indexed and applied by its output stream and channel.
module tsw_mem_map #(
    parameter int STREAMS = 32,
    parameter int CHANS = 256
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [13:0] host_addr,
    input wire logic [15:0] host_wdata,
    input wire logic host_cs,
    input wire logic host_we,
    output logic [15:0] host_rdata,
    output logic host_ack,
    input wire logic [4:0] out_stream,
    input wire logic [7:0] out_chan,
    input wire logic [7:0] cdly_data,
    input wire logic [7:0] vdly_data,
    output logic [4:0] src_stream,
    output logic [7:0] src_chan,
    output logic [7:0] tx_data,
    output logic tx_drive,
    output logic tx_convert,
    output logic [15:0] tx_law_word,
    output logic tx_ber,
    output logic slot_valid
);
    localparam int DEPTH = STREAMS * CHANS;

    // Memories indexed by output stream and channel
    logic [15:0] cml_mem [DEPTH];
    logic [15:0] cmh_mem [DEPTH];
    logic [7:0] dat_mem [DEPTH];
    logic [15:0] ctrl_q;
    logic [15:0] rate_q;
    logic [15:0] host_rdata_q;
    logic host_ack_q;

    // Host address decode
    // (R01) memory space select
    wire mem_space = host_addr[`TSW_MEM_SEL_BIT];
    // (R04) stream and channel index
    wire [4:0] h_stream = host_addr[`TSW_STREAM_HI:`TSW_STREAM_LO];
    wire [7:0] h_chan = host_addr[`TSW_CHAN_HI:`TSW_CHAN_LO];
    wire [12:0] h_idx = {h_stream, h_chan};
    // (R03) memory select from control
    wire [1:0] msel = ctrl_q[`TSW_CTRL_MSEL_HI:`TSW_CTRL_MSEL_LO];
    wire variable_delay_global_enable = ctrl_q[`TSW_CTRL_VAR_EN_BIT];
    // Select held into its answer cycle is one access, not two
    wire host_take = host_cs && !host_ack_q;
    // (R02) register space select
    wire reg_space = !mem_space;
    wire wr_ctrl = host_take && host_we && reg_space && host_addr == `TSW_CTRL_OFFSET;
    wire wr_rate = host_take && host_we && reg_space && host_addr == `TSW_RATE_OFFSET;
    wire wr_mem = host_take && host_we && mem_space;

    // Register file, reset to defined values
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q <= `TSW_CTRL_RESET;
            rate_q <= `TSW_RATE_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= host_wdata;
            if (wr_rate)
                rate_q <= host_wdata;
        end
    end

    // Memory writes; no reset so these map to RAM
    always_ff @(posedge core_clk)
    begin
        if (wr_mem && msel == `TSW_MSEL_CML)
            cml_mem[h_idx] <= host_wdata;
        if (wr_mem && msel == `TSW_MSEL_CMH)
            cmh_mem[h_idx] <= host_wdata;
        if (wr_mem && msel == `TSW_MSEL_DATA)
            dat_mem[h_idx] <= host_wdata[7:0];
    end

    // Read mux; unmapped registers and select code 3 read zero
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        if (mem_space)
        begin
            case (msel)
                `TSW_MSEL_DATA: rd_mux = {8'h00, dat_mem[h_idx]};
                `TSW_MSEL_CML: rd_mux = cml_mem[h_idx];
                `TSW_MSEL_CMH: rd_mux = cmh_mem[h_idx];
                default: rd_mux = 16'h0000;
            endcase
        end
        else if (host_addr == `TSW_CTRL_OFFSET)
            rd_mux = ctrl_q;
        else if (host_addr == `TSW_RATE_OFFSET)
            rd_mux = rate_q;
    end

    // One-cycle registered answer to each new select
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            host_rdata_q <= 16'h0000;
            host_ack_q <= 1'b0;
        end
        else
        begin
            host_rdata_q <= rd_mux;
            host_ack_q <= host_take;
        end
    end
    assign host_rdata = host_rdata_q;
    assign host_ack = host_ack_q;

    // Timeslot side: fetch word of the slot being generated
    // (R15) index by output slot
    wire [12:0] o_idx = {out_stream, out_chan};
    wire [15:0] cur_cml = cml_mem[o_idx];
    wire [15:0] cur_cmh = cmh_mem[o_idx];
    tsw_pkg::tsw_outmode_e mode;
    logic law_conv;
    logic var_delay;
    logic [4:0] d_stream;
    logic [7:0] d_chan;
    logic [7:0] msg_byte;

    tsw_cml_decode u_dec (
        .word(cur_cml),
        .mode(mode),
        .law_conv(law_conv),
        .var_delay(var_delay),
        .src_stream(d_stream),
        .src_chan(d_chan),
        .msg_byte(msg_byte)
    );

    // (R05) channel range by output stream rate, two bits per stream
    wire [1:0] rate_code = rate_q[{out_stream[2:0], 1'b0} +: 2];
    logic in_range;
    always_comb
    begin
        case (tsw_pkg::tsw_rate_e'(rate_code))
            tsw_pkg::TSW_RATE_2M: in_range = out_chan < 8'd32;
            tsw_pkg::TSW_RATE_4M: in_range = out_chan < 8'd64;
            tsw_pkg::TSW_RATE_8M: in_range = out_chan < 8'd128;
            default: in_range = 1'b1;
        endcase
    end

    // (R09) (R10) delay memory choice; global enable gates variable delay
    wire use_var = var_delay && variable_delay_global_enable;
    wire [7:0] sw_data = use_var ? vdly_data : cdly_data;
    // (R06) (R14) output selection by channel mode
    wire is_sw = mode == tsw_pkg::TSW_OUT_SWITCH;
    wire drive_d = in_range && (is_sw || mode == tsw_pkg::TSW_OUT_MESSAGE || mode == tsw_pkg::TSW_OUT_BER);
    wire [7:0] data_d = is_sw ? sw_data : (mode == tsw_pkg::TSW_OUT_MESSAGE ? msg_byte : 8'h00);
    // (R07) (R08) conversion only with law enable in driven switch or message slots
    wire conv_d = drive_d && mode != tsw_pkg::TSW_OUT_BER && law_conv;

    // Registered per-slot outputs
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            src_stream <= 5'h00;
            src_chan <= 8'h00;
            tx_data <= 8'h00;
            tx_drive <= 1'b0;
            tx_convert <= 1'b0;
            tx_law_word <= 16'h0000;
            tx_ber <= 1'b0;
            slot_valid <= 1'b0;
        end
        else
        begin
            // (R12) source fields
            src_stream <= is_sw ? d_stream : 5'h00;
            src_chan <= is_sw ? d_chan : 8'h00;
            tx_data <= data_d;
            tx_drive <= drive_d;
            tx_convert <= conv_d;
            // (R07) high word ignored unless converting
            tx_law_word <= conv_d ? cur_cmh : 16'h0000;
            tx_ber <= in_range && mode == tsw_pkg::TSW_OUT_BER;
            slot_valid <= in_range;
        end
    end

    // Checks
    // (R01) memory write with connection low selected lands in low word
    cml_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R01)
        (wr_mem && msel == `TSW_MSEL_CML) |=> cml_mem[$past(h_idx)] == $past(host_wdata))
        else $error("connection low write lost");
    ctrl_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R02)
        wr_ctrl |=> ctrl_q == $past(host_wdata))
        else $error("control write lost");
    mem_nowrite_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R02)
        (host_cs && host_we && mem_space) |=> $stable(ctrl_q))
        else $error("memory access hit register");
    // New request, then a single answer cycle
    sequence host_new_req_s;
        host_take;
    endsequence
    sequence ack_pulse_s;
        host_ack ##1 !host_ack;
    endsequence
    ack_delay_a: assert property (@(posedge core_clk) disable iff (sys_rst) // host answer timing
        host_new_req_s |=> ack_pulse_s)
        else $error("no single answer");
    range_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R05)
        (rate_code == 2'h0 && out_chan >= 8'd32) |=> !slot_valid && !tx_drive)
        else $error("out of range slot driven");
    src_field_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R12)
        is_sw |=> src_stream == $past(cur_cml[13:9]) && src_chan == $past(cur_cml[8:1]))
        else $error("source fields wrong");
    noconv_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R07)
        !law_conv |=> !tx_convert && tx_law_word == 16'h0000)
        else $error("conversion without enable");
    delay_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R10)
        (is_sw && in_range && use_var) |=> tx_data == $past(vdly_data))
        else $error("variable delay not used");
    const_delay_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R09)
        (is_sw && in_range && !use_var) |=> tx_data == $past(cdly_data))
        else $error("constant delay not used");
    tristate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // (R14)
        (mode == tsw_pkg::TSW_OUT_TRISTATE) |=> !tx_drive)
        else $error("tristate slot driven");
endmodule // tsw_mem_map

/* File: rtl/tsw_pkg.sv */
package tsw_pkg;
    typedef enum logic [1:0] {
        TSW_RATE_2M,
        TSW_RATE_4M,
        TSW_RATE_8M,
        TSW_RATE_16M
    } tsw_rate_e;
    typedef enum logic [2:0] {
        TSW_OUT_SWITCH,
        TSW_OUT_TRISTATE,
        TSW_OUT_MESSAGE,
        TSW_OUT_BER,
        TSW_OUT_RESERVED
    } tsw_outmode_e;
endpackage

/* File: rtl/tsw_regs.svh */
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH
// Host address layout
`define TSW_ADDR_W 14
`define TSW_MEM_SEL_BIT 13
`define TSW_STREAM_HI 12
`define TSW_STREAM_LO 8
`define TSW_CHAN_HI 7
`define TSW_CHAN_LO 0
// Register space (memory_space_select_bit low)
`define TSW_CTRL_OFFSET 14'h0000
`define TSW_RATE_OFFSET 14'h0001
`define TSW_CTRL_RESET 16'h0000
`define TSW_RATE_RESET 16'h0000
`define TSW_CTRL_MSEL_HI 1
`define TSW_CTRL_MSEL_LO 0
`define TSW_CTRL_VAR_EN_BIT 2
// Memory select codes in control bits 1..0
`define TSW_MSEL_DATA 2'h0
`define TSW_MSEL_CML 2'h1
`define TSW_MSEL_CMH 2'h2
// Low connection word fields
`define TSW_CML_LAW_EN_BIT 15
`define TSW_CML_VC_BIT 14
`define TSW_CML_SRC_STR_HI 13
`define TSW_CML_SRC_STR_LO 9
`define TSW_CML_SRC_CH_HI 8
`define TSW_CML_SRC_CH_LO 1
`define TSW_CML_SPECIAL_BIT 0
`define TSW_CML_MODE_HI 2
`define TSW_CML_MODE_LO 1
`define TSW_CML_MSG_HI 10
`define TSW_CML_MSG_LO 3
`endif

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] host_addr;
    logic [15:0] host_wdata, host_rdata, tx_law_word;
    logic host_cs, host_we, host_ack, tx_drive, tx_convert, tx_ber, slot_valid;
    logic [4:0] out_stream = 5'h00;
    logic [7:0] out_chan = 8'h00;
    logic [7:0] cdly_data = 8'h3c;
    logic [7:0] vdly_data = 8'hc3;
    logic [4:0] src_stream;
    logic [7:0] src_chan, tx_data;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    tsw_mem_map DUT (.core_clk(core_clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_cs(host_cs), .host_we(host_we), .host_rdata(host_rdata), .host_ack(host_ack),
        .out_stream(out_stream), .out_chan(out_chan), .cdly_data(cdly_data), .vdly_data(vdly_data),
        .src_stream(src_stream), .src_chan(src_chan), .tx_data(tx_data), .tx_drive(tx_drive),
        .tx_convert(tx_convert), .tx_law_word(tx_law_word), .tx_ber(tx_ber), .slot_valid(slot_valid));
    tsw_host_model host (.core_clk(core_clk), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_cs(host_cs), .host_we(host_we), .host_rdata(host_rdata), .host_ack(host_ack));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard: the tests need under 150 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic ok;
        host.access(a, d, 1'b1, r, ok);
        check(16'(ok), 16'h0001, "write ack");
    endtask
    task automatic rd(input logic [13:0] a, input logic [15:0] e, input string m);
        logic [15:0] r;
        logic ok;
        host.access(a, 16'h0000, 1'b0, r, ok);
        check(16'(ok), 16'h0001, "read ack");
        check(r, e, m);
    endtask
    function automatic logic [13:0] maddr(input logic [4:0] s, input logic [7:0] c);
        return {1'b1, s, c};
    endfunction
    // Present a timeslot and let its registered result land
    task automatic slot(input logic [4:0] s, input logic [7:0] c);
        @(posedge core_clk);
        out_stream <= s;
        out_chan <= c;
        @(posedge core_clk);
        #1;
    endtask
    task automatic t_regs();
        rd(14'h0000, 16'h0000, "ctrl reset");
        rd(14'h0001, 16'h0000, "rate reset");
        wr(14'h0001, 16'h00c0);
        rd(14'h0001, 16'h00c0, "rate readback");
        rd(14'h0005, 16'h0000, "unmapped read");
        $display("t_regs done");
    endtask
    task automatic t_mem();
        wr(14'h0000, 16'h0002);
        wr(maddr(5'h03, 8'h05), 16'h5a5a);
        wr(14'h0000, 16'h0001);
        wr(maddr(5'h03, 8'h05), 16'h1342);
        wr(maddr(5'h1f, 8'hff), 16'h0003);
        wr(14'h0000, 16'h0000);
        wr(maddr(5'h03, 8'h05), 16'hbe3c);
        rd(maddr(5'h03, 8'h05), 16'h003c, "data memory");
        wr(14'h0000, 16'h0001);
        rd(maddr(5'h03, 8'h05), 16'h1342, "conn low");
        rd(maddr(5'h1f, 8'hff), 16'h0003, "conn low last");
        wr(14'h0000, 16'h0002);
        rd(maddr(5'h03, 8'h05), 16'h5a5a, "conn high");
        wr(14'h0000, 16'h0003);
        rd(maddr(5'h03, 8'h05), 16'h0000, "select code 3");
        // Code 3 write must miss every memory; t_switch then sees the old words
        wr(maddr(5'h03, 8'h05), 16'hffff);
        rd(14'h0000, 16'h0003, "ctrl readback");
        $display("t_mem done");
    endtask
    task automatic t_switch();
        slot(5'h03, 8'h05);
        check(16'(src_stream), 16'h0009, "src stream");
        check(16'(src_chan), 16'h00a1, "src chan");
        check({tx_data, 7'h00, tx_drive}, 16'h3c01, "const data");
        check({tx_law_word[14:0], tx_convert}, 16'h0000, "no convert");
        // High word already holds 5a5a, written before enable
        wr(14'h0000, 16'h0001);
        wr(maddr(5'h03, 8'h05), 16'h9342);
        slot(5'h03, 8'h05);
        check(tx_law_word, 16'h5a5a, "law word");
        check({tx_data, 7'h00, tx_convert}, 16'h3c01, "convert on");
        // Global enable before any channel picks variable delay
        wr(14'h0000, 16'h0005);
        wr(maddr(5'h03, 8'h05), 16'h5342);
        slot(5'h03, 8'h05);
        check(16'(tx_data), 16'h00c3, "variable data");
        $display("t_switch done");
    endtask
    task automatic t_special();
        logic [3:0] drv = 4'b0110;
        for (int p = 0; p < 4; p++)
        begin
            wr(maddr(5'h03, 8'h05), 16'h04b1 | 16'(p << 1));
            slot(5'h03, 8'h05);
            check(16'(tx_drive), 16'(drv[p]), "special drive");
            check(16'(tx_ber), 16'(p == 2), "ber flag");
            check(16'(src_stream), 16'h0000, "no source");
            if (p == 1 || p == 2)
                check(16'(tx_data), (p == 1) ? 16'h0096 : 16'h0000, "special data");
        end
        $display("t_special done");
    endtask
    task automatic t_rate();
        for (int r = 0; r < 4; r++)
        begin
            wr(14'h0001, 16'(r << 6));
            slot(5'h03, 8'((32 << r) - 1));
            check(16'(slot_valid), 16'h0001, "last usable");
            if (r < 3)
            begin
                slot(5'h03, 8'(32 << r));
                check({15'h0000, slot_valid | tx_drive}, 16'h0000, "beyond range");
            end
        end
        $display("t_rate done");
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_mem();
        t_switch();
        t_special();
        t_rate();
        conclude();
    end
endmodule // tb

/* File: testbench/tsw_host_model.sv */
`timescale 1ns/1ps
// Host bus master: select held until ack is seen, with a bounded wait
module tsw_host_model (
    input wire logic core_clk,
    output logic [13:0] host_addr,
    output logic [15:0] host_wdata,
    output logic host_cs,
    output logic host_we,
    input wire logic [15:0] host_rdata,
    input wire logic host_ack
);
    // Idle bus from time zero
    initial
    begin
        host_addr = 14'h0000;
        host_wdata = 16'h0000;
        host_cs = 1'b0;
        host_we = 1'b0;
    end
    // Request and qualifiers stand until the edge that samples ack high
    task automatic access(input logic [13:0] a, input logic [15:0] d, input logic we,
                          output logic [15:0] r, output logic ok);
        ok = 1'b0;
        r = 16'h0000;
        @(posedge core_clk);
        host_addr <= a;
        host_wdata <= d;
        host_we <= we;
        host_cs <= 1'b1;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(posedge core_clk);
            if (host_ack === 1'b1)
            begin
                r = host_rdata;
                ok = 1'b1;
            end
        end
        // Released select and write go low and address and data carry the inverse, so a design latching late sees garbage
        host_cs <= 1'b0;
        host_we <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask
endmodule // tsw_host_model
